// *** hdl/dgcc_defs.vh ***
// shared constants for the dac group clear control block
`ifndef DGCC_DEFS_VH
`define DGCC_DEFS_VH
`define DGCC_CHANNELS    12
`define DGCC_CODE_WIDTH  12
`define DGCC_CLEAR_CODE  12'h000
`define DGCC_SYNC_STAGES 2
`endif

// *** hdl/dgcc_sync.v ***
// two-flop synchroniser for the active-low clear inputs
`timescale 1ns/10ps
module dgcc_sync (
	input  wire clock,
	input  wire sys_rst,
	input  wire async_in_n,
	output reg  sync_out_n
);
	reg stage1_n;

	// inputs idle high, so reset to the released level
	always @(posedge clock) begin
		if (sys_rst) begin
			stage1_n   <= 1'b1;
			sync_out_n <= 1'b1;
		end else begin
			stage1_n   <= async_in_n;
			sync_out_n <= stage1_n;
		end
	end
endmodule

// *** hdl/dgcc_clear_control.v ***
// dac group clear control: per-channel output latches with two clear groups
// What this block does
// - clear input low puts every channel assigned to it into clear state
// - entering clear loads each affected output latch with the clear code
// - clear never alters any channel's data register
// - on release each affected latch reloads from its data register
// - release reload ignores the channel's synchronous-load enable bit
// - clear input high lets its channels load normally, except channels the other clear input still holds low
// - second clear input acts the same on its own assigned channels
`timescale 1ns/10ps
`include "dgcc_defs.vh"
module dgcc_clear_control #(
	parameter CHANNELS   = `DGCC_CHANNELS,
	parameter CODE_WIDTH = `DGCC_CODE_WIDTH,
	parameter [CODE_WIDTH-1:0] CLEAR_CODE = `DGCC_CLEAR_CODE
) (
	input  wire                           clock,
	input  wire                           sys_rst,
	// clear pins from the host
	input  wire                           group_a_clear_n,
	input  wire                           group_b_clear_n,
	// channel assignment to the two clear pins
	input  wire [CHANNELS-1:0]            group_a_mask,
	input  wire [CHANNELS-1:0]            group_b_mask,
	// data path and load controls
	input  wire [CHANNELS-1:0]            data_write,
	input  wire [CHANNELS*CODE_WIDTH-1:0] data_in,
	input  wire [CHANNELS-1:0]            sync_load_enable,
	input  wire                           load_strobe,
	// registered channel state
	output reg  [CHANNELS*CODE_WIDTH-1:0] data_reg,
	output reg  [CHANNELS*CODE_WIDTH-1:0] latch_out,
	output reg  [CHANNELS-1:0]            clear_active
);
	// latch source codes, chosen per channel every cycle
	localparam [2:0] SRC_HOLD    = 3'h0;
	localparam [2:0] SRC_CLEAR   = 3'h1;
	localparam [2:0] SRC_RESTORE = 3'h2;
	localparam [2:0] SRC_DIRECT  = 3'h3;
	localparam [2:0] SRC_STORED  = 3'h4;

	// per-channel clear state
	localparam ST_RUN   = 1'b0;
	localparam ST_CLEAR = 1'b1;

	wire                           a_clr_n;
	wire                           b_clr_n;
	wire [CHANNELS-1:0]            a_hit;
	wire [CHANNELS-1:0]            b_hit;
	wire [CHANNELS-1:0]            clear_req;
	wire [CHANNELS-1:0]            release_now;
	reg  [CHANNELS-1:0]            next_clear_active;
	reg  [3*CHANNELS-1:0]          latch_src;
	reg  [CHANNELS*CODE_WIDTH-1:0] next_data_reg;
	reg  [CHANNELS*CODE_WIDTH-1:0] next_latch;
	// loop indices, one per process so none has two drivers
	integer                        m;
	integer                        i;
	integer                        j;
	integer                        k;

	// pick one channel's code out of a packed bus
	function [CODE_WIDTH-1:0] code_at;
		input [CHANNELS*CODE_WIDTH-1:0] bus;
		input integer                   idx;
		begin
			code_at = bus[idx*CODE_WIDTH +: CODE_WIDTH];
		end
	endfunction

	// return a bus with one channel's code replaced
	function [CHANNELS*CODE_WIDTH-1:0] with_code;
		input [CHANNELS*CODE_WIDTH-1:0] bus;
		input integer                   idx;
		input [CODE_WIDTH-1:0]          code;
		begin
			with_code                               = bus;
			with_code[idx*CODE_WIDTH +: CODE_WIDTH] = code;
		end
	endfunction

	// channels that one clear input currently holds
	function [CHANNELS-1:0] group_hit;
		input                clr_n;
		input [CHANNELS-1:0] mask;
		begin
			group_hit = mask & {CHANNELS{~clr_n}};
		end
	endfunction

	// choose where one channel's latch takes its next value from
	function [2:0] pick_source;
		input clearing;
		input leaving;
		input sync_mode;
		input write;
		input strobe;
		begin
			if (clearing)
				pick_source = SRC_CLEAR;
			else if (leaving)
				pick_source = SRC_RESTORE;
			// immediate load, or a write meeting the strobe
			else if (write && (!sync_mode || strobe))
				pick_source = SRC_DIRECT;
			else if (sync_mode && strobe)
				pick_source = SRC_STORED;
			else
				pick_source = SRC_HOLD;
		end
	endfunction

	dgcc_sync u_sync_a (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.async_in_n (group_a_clear_n),
		.sync_out_n (a_clr_n)
	);

	dgcc_sync u_sync_b (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.async_in_n (group_b_clear_n),
		.sync_out_n (b_clr_n)
	);

	assign a_hit     = group_hit(a_clr_n, group_a_mask);
	assign b_hit     = group_hit(b_clr_n, group_b_mask);
	assign clear_req = a_hit | b_hit;

	always @* begin
		next_clear_active = clear_active;
		for (m = 0; m < CHANNELS; m = m + 1) begin
			case (clear_active[m])
				ST_RUN: begin
					// enter clear while the pin is low
					if (clear_req[m])
						next_clear_active[m] = ST_CLEAR;
				end
				ST_CLEAR: begin
					// leave clear once every pin assigned to the channel is high
					if (!clear_req[m])
						next_clear_active[m] = ST_RUN;
				end
				default: begin
					next_clear_active[m] = ST_RUN;
				end
			endcase
		end
	end

	assign release_now = clear_active & ~next_clear_active;

	// per-channel latch source
	always @* begin
		latch_src = {3*CHANNELS{1'b0}};
		for (i = 0; i < CHANNELS; i = i + 1) begin
			latch_src[3*i +: 3] = pick_source(next_clear_active[i], release_now[i],
				sync_load_enable[i], data_write[i], load_strobe);
		end
	end

	// data register follows host writes only
	always @* begin
		next_data_reg = data_reg;
		for (j = 0; j < CHANNELS; j = j + 1) begin
			if (data_write[j]) begin
				next_data_reg = with_code(next_data_reg, j, code_at(data_in, j));
			end
		end
	end

	// next latch value per channel
	always @* begin
		next_latch = latch_out;
		for (k = 0; k < CHANNELS; k = k + 1) begin
			case (latch_src[3*k +: 3])
				SRC_CLEAR: begin
					next_latch = with_code(next_latch, k, CLEAR_CODE);
				end
				SRC_RESTORE: begin
					next_latch = with_code(next_latch, k, code_at(data_reg, k));
				end
				SRC_DIRECT: begin
					next_latch = with_code(next_latch, k, code_at(data_in, k));
				end
				SRC_STORED: begin
					next_latch = with_code(next_latch, k, code_at(data_reg, k));
				end
				default: begin
					next_latch = with_code(next_latch, k, code_at(latch_out, k));
				end
			endcase
		end
	end

	always @(posedge clock) begin
		// reset drops every channel to code zero outside clear
		if (sys_rst) begin
			data_reg     <= {CHANNELS*CODE_WIDTH{1'b0}};
			latch_out    <= {CHANNELS*CODE_WIDTH{1'b0}};
			clear_active <= {CHANNELS{1'b0}};
		end else begin
			data_reg     <= next_data_reg;
			latch_out    <= next_latch;
			clear_active <= next_clear_active;
		end
	end
endmodule

// *** verification/dgcc_host.sv ***
// host model driving the two clear pins
`timescale 1ns/10ps
module dgcc_host (input wire clock, input wire [1:0] want, output logic group_a_clear_n = 1,
	output logic group_b_clear_n = 1);
	always @(posedge clock) {group_b_clear_n, group_a_clear_n} <= ~want;
endmodule

// *** verification/dgcc_props.sv ***
// assertions for the clear control block
`timescale 1ns/10ps
module dgcc_props #(parameter CHANNELS = 12, CODE_WIDTH = 12) (
	input wire clock, sys_rst, group_a_clear_n, group_b_clear_n,
	input wire [CHANNELS-1:0] group_a_mask, group_b_mask, data_write, sync_load_enable, clear_active,
	input wire [CHANNELS*CODE_WIDTH-1:0] data_in, data_reg, latch_out);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [1:0] up = 0;
	always @(posedge clock) up <= sys_rst ? 2'h0 : up + {1'b0, up != 2'h3};
	AST_CLR_A: assert property (up == 3 && !$past(group_a_clear_n, 3) |->
		&(clear_active | ~group_a_mask)) else $error("group a missed");
	AST_CLR_B: assert property (up == 3 && !$past(group_b_clear_n, 3) |->
		&(clear_active | ~group_b_mask)) else $error("group b missed");
	AST_IDLE: assert property (up == 3 && $past(group_a_clear_n & group_b_clear_n, 3) |->
		clear_active == 0) else $error("stray clear");
	AST_CODE: assert property (clear_active[0] |->
		latch_out[11:0] == 12'h000) else $error("no clear code");
	AST_KEEP: assert property (!$past(data_write[0]) |->
		$stable(data_reg[11:0])) else $error("data moved");
	AST_WR: assert property ($past(data_write[0]) |->
		data_reg[11:0] == $past(data_in[11:0])) else $error("write lost");
	AST_BACK: assert property ($fell(clear_active[0]) && !$past(data_write[0]) |->
		latch_out[11:0] == data_reg[11:0]) else $error("no restore");
	AST_LOAD: assert property ($past(data_write[0] & ~sync_load_enable[0] & ~clear_active[0])
		&& !clear_active[0] |-> latch_out[11:0] == data_reg[11:0]) else $error("no load");
endmodule
bind dgcc_clear_control dgcc_props #(.CHANNELS(CHANNELS), .CODE_WIDTH(CODE_WIDTH)) dgcc_props_inst (.*);

// *** verification/test_dac_group_clear_control.sv ***
// bench for the clear control block
`timescale 1ns/10ps
`include "dgcc_defs.vh"
module test_dac_group_clear_control;
	logic clock = 0, sys_rst = 1, load_strobe = 0;
	logic [1:0] want = 0;
	logic [11:0] group_a_mask = 0, group_b_mask = 0, data_write = 0, sync_load_enable = 0, cp = 0;
	logic [143:0] data_in = 0, d = 0, l = 0;
	wire [143:0] data_reg, latch_out;
	wire [11:0] clear_active;
	wire group_a_clear_n, group_b_clear_n;
	logic [299:0] q[$], e;
	int err_total = 0, comparisons = 0;
	event done;
	always #20 clock = ~clock;
	dgcc_host dgcc_host_inst (.*);
	dgcc_clear_control dgcc_clear_control_inst (.*);
	task cmp(logic [287:0] e); comparisons++; if (e !== {data_reg, latch_out}) begin err_total++;
		$display("wrong value at %0t data or latch", $time); end endtask
	task cmp_clr(logic [11:0] x); comparisons++; if (x !== clear_active) begin err_total++;
		$display("wrong value at %0t clear state", $time); end endtask
	always @(done) begin e = q.pop_front();
		cmp(e[287:0]);
		cmp_clr(e[299:288]);
	end
	task go(int n); q.push_back({cp, d, l}); repeat (n) @(negedge clock); ->done; endtask
	task fix(logic [143:0] v); for (int i = 0; i < 12; i++) if (cp[i]) l[i*12+:12] = v[i*12+:12]; endtask
	task wrt(logic [11:0] s); sync_load_enable = s; data_write = 12'hFFF;
		for (int i = 0; i < 144; i += 12) begin data_in[i+:12] = 12'($urandom);
			if (!cp[i/12] && !s[i/12]) l[i+:12] = data_in[i+:12]; end
		d = data_in; @(negedge clock) data_write = 0; endtask
	task tally_and_finish; $display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish; endtask
	initial begin #20000 err_total++; tally_and_finish; end
	initial begin void'($urandom(89194)); repeat (4) @(negedge clock); sys_rst = 0;
		group_a_mask = 12'($urandom) | 12'h001; group_b_mask = 12'($urandom) | 12'h001;
		wrt(12'h000); go(0);
		$display("direct write test done");
		for (int w = 1; w < 4; w++) begin
			want = w[1:0]; cp = {12{w[0]}} & group_a_mask | {12{w[1]}} & group_b_mask;
			fix({12{`DGCC_CLEAR_CODE}}); go(5);
			wrt(12'hFFF); go(0);
			want = 0; fix(d); cp = 0; go(5);
			$display("clear pass %0d done", w); end
		load_strobe = 1; @(negedge clock) load_strobe = 0; l = d; go(0);
		$display("strobe load test done");
		@(negedge clock) tally_and_finish; end
endmodule
